/* rtl/gbar_defines.vh */
// Purpose: offsets, field positions and reset values of the bypass/irq register bank
// Assumes: 32-bit byte-addressed register port, byte offsets as printed
// Notes: definitions only
`ifndef GBAR_DEFINES_VH
`define GBAR_DEFINES_VH
`define GBAR_OFF_BYPASS      12'h044
`define GBAR_OFF_ALT_TAG     12'h048
`define GBAR_OFF_IRQ_CTRL    12'h050
`define GBAR_OFF_IRQ_ACK     12'h054
`define GBAR_BIT_UPDATE      31
`define GBAR_BIT_ABORT       20
`define GBAR_INSN_HI         19
`define GBAR_INSN_LO         18
`define GBAR_PRIV_HI         17
`define GBAR_PRIV_LO         16
`define GBAR_SH_HI           13
`define GBAR_SH_LO           12
`define GBAR_ALLOC_HI        11
`define GBAR_ALLOC_LO        8
`define GBAR_BIT_MT_EN       4
`define GBAR_MATTR_HI        3
`define GBAR_MATTR_LO        0
`define GBAR_BYPASS_MASK     32'h801f3f1f
`define GBAR_TYPE_FIELD_MASK 32'h00003f1f
`define GBAR_PERM_FIELD_MASK 32'h000f0000
`define GBAR_BYPASS_RESET    32'h00001000
`define GBAR_IRQ_MASK        32'h00000007
`define GBAR_IRQ_ACK_DELAY   4'h2
`define GBAR_MT_NORM_WB      4'hf
`define GBAR_MT_NORM_WT      4'ha
`endif

/* rtl/gbar_regs.v */
// Purpose: global bypass attributes, alternate tag and interrupt-enable registers
// Assumes: one clock, registers reached through a simple word register port
// Notes: attribute outputs registered; datapath override is registered one cycle
`include "gbar_defines.vh"

// Behaviour
// - read access type override; writes emitted as data whenever overrides apply
// - privilege override: pass, unprivileged or privileged
// - shareability override: non, pass, outer, inner
// - allocation top bit set replaces read, write and transient hints
// - allocation hints untouched unless resulting type is normal write-back or write-through
// - memory type override bit selects the attribute field value
// - reserved bypass register bits read zero
// - bypass register writable only while update flag is zero
// - overrides apply to non-secure streams only while translation disabled
// - without type override support writes clear those fields: shareability becomes non, the others pass through
// - without permission override support those fields pass through, read zero
// - fields for attributes the outgoing bus lacks are cleared by writes
// - update flag resets to zero; other fields take chosen defaults
// - after flag clears, new attributes apply to new transactions
// - write during pending update ignored; first value completes
// - write without update flag ignored entirely
// - written value reads back at once before completion
// - alternate tag register is 32-bit read-write store
// - three interrupt enables reset zero, upper bits reserved
// - each enable gates wired edge output and message write of its source
// - each enable mirrored into acknowledge register once effective
// - abort bit aborts every bypass transaction
// - interrupt control at 0x50, acknowledge mirror at 0x54
module gbar_regs #(
  parameter TYPE_OVR_SUPPORTED = 1,
  parameter PERM_OVR_SUPPORTED = 1,
  parameter [31:0] OUT_ATTR_MASK = 32'hffffffff,
  parameter ALT_TAG_SUPPORTED = 1,
  parameter [31:0] BYPASS_RESET = `GBAR_BYPASS_RESET
) (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [11:0] reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  input  wire        translation_enable,
  input  wire        txn_valid,
  input  wire        txn_nonsecure,
  input  wire        txn_is_write,
  input  wire        txn_insn,
  input  wire        txn_priv,
  input  wire [1:0]  txn_share,
  input  wire [3:0]  txn_memtype,
  input  wire [2:0]  txn_alloc,
  input  wire        old_txn_outstanding,
  output reg         out_valid,
  output reg         out_abort,
  output reg         out_insn,
  output reg         out_priv,
  output reg  [1:0]  out_share,
  output reg  [3:0]  out_memtype,
  output reg  [2:0]  out_alloc,
  output reg  [31:0] out_alt_tag,
  input  wire [2:0]  irq_event,
  input  wire [2:0]  msi_req,
  output reg  [2:0]  irq_edge,
  output reg  [2:0]  msi_fire,
  output reg  [2:0]  irq_en_effective
);

//////////////////////////////////////////////////////////////////////////////
// write masks from implementation options
function [31:0] gbar_wmask;
  input dummy;
  begin
    gbar_wmask = `GBAR_BYPASS_MASK & OUT_ATTR_MASK;
    if (TYPE_OVR_SUPPORTED == 0)
      gbar_wmask = gbar_wmask & ~`GBAR_TYPE_FIELD_MASK;
    if (PERM_OVR_SUPPORTED == 0)
      gbar_wmask = gbar_wmask & ~`GBAR_PERM_FIELD_MASK;
  end
endfunction

localparam [31:0] WMASK = gbar_wmask(1'b0);

//////////////////////////////////////////////////////////////////////////////
// bypass register and update handshake
localparam [2:0] UPD_IDLE  = 3'b001;
localparam [2:0] UPD_DRAIN = 3'b010;
localparam [2:0] UPD_LATCH = 3'b100;

reg  [31:0] bypass_r;
reg  [31:0] live_r;
reg  [2:0]  upd_state_r;
reg  [31:0] alt_tag_r;
reg  [2:0]  irq_ctrl_r;
reg  [2:0]  irq_ack_r;
reg  [3:0]  irq_cnt_r;
wire        upd_pending;
wire        bypass_wr;
wire        active;

assign upd_pending = bypass_r[`GBAR_BIT_UPDATE];
assign bypass_wr   = reg_wr && (reg_addr == `GBAR_OFF_BYPASS);
assign active      = ~translation_enable & txn_nonsecure;

always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    bypass_r    <= BYPASS_RESET & `GBAR_BYPASS_MASK & ~32'h80000000;
    live_r      <= BYPASS_RESET & `GBAR_BYPASS_MASK & ~32'h80000000;
    upd_state_r <= UPD_IDLE;
  end else begin
    case (upd_state_r)
      UPD_IDLE: begin
        // only full writes with update set are taken
        if (bypass_wr && reg_wdata[`GBAR_BIT_UPDATE]) begin
          bypass_r    <= (reg_wdata & WMASK) | 32'h80000000;
          upd_state_r <= UPD_DRAIN;
        end
      end
      UPD_DRAIN: begin
        // further writes ignored while pending
        if (!old_txn_outstanding)
          upd_state_r <= UPD_LATCH;
      end
      UPD_LATCH: begin
        live_r      <= bypass_r & ~32'h80000000;
        bypass_r[`GBAR_BIT_UPDATE] <= 1'b0;
        upd_state_r <= UPD_IDLE;
      end
      default: upd_state_r <= UPD_IDLE;
    endcase
  end
end

//////////////////////////////////////////////////////////////////////////////
// alternate tag and interrupt control
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    alt_tag_r  <= 32'h00000000;
    irq_ctrl_r <= 3'h0;
  end else if (reg_wr) begin
    if (reg_addr == `GBAR_OFF_ALT_TAG && ALT_TAG_SUPPORTED != 0)
      alt_tag_r <= reg_wdata;
    if (reg_addr == `GBAR_OFF_IRQ_CTRL)
      irq_ctrl_r <= reg_wdata[2:0];
  end
end

// enable change takes effect, then mirrors into acknowledge
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    irq_ack_r        <= 3'h0;
    irq_cnt_r        <= 4'h0;
    irq_en_effective <= 3'h0;
  end else begin
    irq_en_effective <= irq_ctrl_r;
    if (irq_ctrl_r != irq_ack_r) begin
      if (irq_cnt_r == `GBAR_IRQ_ACK_DELAY) begin
        irq_ack_r <= irq_en_effective;
        irq_cnt_r <= 4'h0;
      end else begin
        irq_cnt_r <= irq_cnt_r + 4'h1;
      end
    end else begin
      irq_cnt_r <= 4'h0;
    end
  end
end

always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    irq_edge <= 3'h0;
    msi_fire <= 3'h0;
  end else begin
    irq_edge <= irq_event & irq_en_effective & irq_ack_r;
    msi_fire <= msi_req & irq_en_effective & irq_ack_r;
  end
end

//////////////////////////////////////////////////////////////////////////////
// register read
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    reg_rdata <= 32'h00000000;
  end else if (reg_rd) begin
    case (reg_addr)
      `GBAR_OFF_BYPASS:   reg_rdata <= bypass_r & `GBAR_BYPASS_MASK;
      `GBAR_OFF_ALT_TAG:  reg_rdata <= (ALT_TAG_SUPPORTED != 0) ? alt_tag_r : 32'h00000000;
      `GBAR_OFF_IRQ_CTRL: reg_rdata <= {29'h0, irq_ctrl_r};
      `GBAR_OFF_IRQ_ACK:  reg_rdata <= {29'h0, irq_ack_r};
      default:            reg_rdata <= 32'h00000000;
    endcase
  end
end

//////////////////////////////////////////////////////////////////////////////
// bypass attribute datapath
reg        insn_nxt;
reg        priv_nxt;
reg [1:0]  share_nxt;
reg [3:0]  mt_nxt;
reg [2:0]  alloc_nxt;

always @* begin
  insn_nxt  = txn_insn;
  priv_nxt  = txn_priv;
  share_nxt = txn_share;
  mt_nxt    = txn_memtype;
  alloc_nxt = txn_alloc;
  if (active) begin
    if (live_r[`GBAR_INSN_HI])
      insn_nxt = live_r[`GBAR_INSN_LO];
    if (txn_is_write)
      insn_nxt = 1'b0;
    if (live_r[`GBAR_PRIV_HI])
      priv_nxt = live_r[`GBAR_PRIV_LO];
    if (live_r[`GBAR_SH_HI:`GBAR_SH_LO] != 2'b01)
      share_nxt = live_r[`GBAR_SH_HI:`GBAR_SH_LO];
    if (live_r[`GBAR_BIT_MT_EN])
      mt_nxt = live_r[`GBAR_MATTR_HI:`GBAR_MATTR_LO];
    if (live_r[`GBAR_ALLOC_HI] &&
        (mt_nxt == `GBAR_MT_NORM_WB || mt_nxt == `GBAR_MT_NORM_WT))
      alloc_nxt = live_r[`GBAR_ALLOC_HI-1:`GBAR_ALLOC_LO];
  end
end

always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    out_valid   <= 1'b0;
    out_abort   <= 1'b0;
    out_insn    <= 1'b0;
    out_priv    <= 1'b0;
    out_share   <= 2'h0;
    out_memtype <= 4'h0;
    out_alloc   <= 3'h0;
    out_alt_tag <= 32'h00000000;
  end else begin
    out_valid   <= txn_valid;
    out_abort   <= txn_valid & active & live_r[`GBAR_BIT_ABORT];
    out_insn    <= insn_nxt;
    out_priv    <= priv_nxt;
    out_share   <= share_nxt;
    out_memtype <= mt_nxt;
    out_alloc   <= alloc_nxt;
    out_alt_tag <= active ? alt_tag_r : 32'h00000000;
  end
end

endmodule

/* tb/gbar_regs_properties.sv */
// Purpose: port checker for the bypass and irq register bank
// Assumes: one clock, async active-low reset
// Notes: bound to every gbar_regs instance
module gbar_regs_chk (
  input wire        clk_sys,
  input wire        resetn,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire        translation_enable,
  input wire        txn_valid,
  input wire        txn_nonsecure,
  input wire        out_valid,
  input wire        out_abort,
  input wire [2:0]  irq_event,
  input wire [2:0]  msi_req,
  input wire [2:0]  irq_edge,
  input wire [2:0]  msi_fire,
  input wire [2:0]  irq_en_effective
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_en_wr;
    reg_wr && reg_addr == 12'h050 && reg_wdata[0] && !irq_en_effective[0];
  endsequence
  a_en_mirror: assert property (s_en_wr |=> ##[0:7] irq_en_effective[0])
    else $error("enable not mirrored");
  a_txn_latency: assert property (txn_valid |=> out_valid)
    else $error("txn output missing");
  a_abort_cause: assert property (out_abort |-> $past(txn_valid && txn_nonsecure))
    else $error("abort without bypass txn");
  a_bypass_rsvd: assert property (reg_rd && reg_addr == 12'h044 |=>
    (reg_rdata & 32'h7fe0c0e0) == 32'h0) else $error("bypass reserved bits set");
  a_irq_rsvd: assert property (reg_rd && reg_addr[11:3] == 9'h00a |=>
    reg_rdata[31:3] == 29'h0) else $error("irq reserved bits set");
  a_edge_gated: assert property (|irq_edge |->
    (irq_edge & ~($past(irq_event) & $past(irq_en_effective))) == 3'h0)
    else $error("wired edge not gated");
  a_msi_gated: assert property (|msi_fire |->
    (msi_fire & ~($past(msi_req) & $past(irq_en_effective))) == 3'h0)
    else $error("message write not gated");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
endmodule
bind gbar_regs gbar_regs_chk u_chk (.clk_sys, .resetn, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .translation_enable, .txn_valid, .txn_nonsecure, .out_valid,
  .out_abort, .irq_event, .msi_req, .irq_edge, .msi_fire, .irq_en_effective);

/* tb/gbar_drain_model.sv */
// Purpose: downstream traffic model for the bypass drain
// Assumes: old traffic drains 12 cycles after the last txn
// Notes: holds old_txn_outstanding while traffic is in flight
module gbar_drain_model (
  input  wire clk_sys,
  input  wire resetn,
  input  wire txn_valid,
  output wire old_txn_outstanding
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] cnt_r;
  assign old_txn_outstanding = cnt_r != 4'h0;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      cnt_r <= 4'h0;
    else if (txn_valid)
      cnt_r <= 4'hc;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule

/* tb/global_bypass_attr_irq_regs_tb_top.sv */
// Purpose: self-checking bench for the bypass and irq register bank
// Assumes: 25 MHz clk_sys, async active-low resetn
// Notes: drain model stands in for downstream traffic
`include "gbar_defines.vh"
module global_bypass_attr_irq_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg  [11:0] reg_addr = 12'h0;
  reg  [31:0] reg_wdata = 32'h0, d;
  reg         translation_enable = 1'b0, txn_valid = 1'b0, txn_is_write = 1'b0;
  reg         txn_nonsecure = 1'b1;
  reg  [2:0]  irq_event = 3'h0, msi_req = 3'h0;
  wire [31:0] reg_rdata;
  wire        out_valid, out_abort, out_insn, out_priv, old_txn_outstanding;
  wire [1:0]  out_share;
  wire [3:0]  out_memtype;
  wire [2:0]  out_alloc, irq_edge, msi_fire, irq_en_effective;
  integer     mismatches = 0, samples_checked = 0, cycles = 0;
  gbar_regs u_dut (.clk_sys, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .translation_enable, .txn_valid, .txn_nonsecure, .txn_is_write, .txn_insn(1'b1),
    .txn_priv(1'b1), .txn_share(2'h2), .txn_memtype(4'h5), .txn_alloc(3'h2),
    .old_txn_outstanding, .out_valid, .out_abort, .out_insn, .out_priv, .out_share,
    .out_memtype, .out_alloc, .out_alt_tag(), .irq_event, .msi_req, .irq_edge, .msi_fire,
    .irq_en_effective);
  gbar_drain_model u_drain (.clk_sys, .resetn, .txn_valid, .old_txn_outstanding);
  always #20 clk_sys = ~clk_sys;
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [11:0] a, input [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input [11:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task txn(input w, input [12:0] exp);
    @(posedge clk_sys);
    txn_valid <= 1'b1;
    txn_is_write <= w;
    @(posedge clk_sys);
    txn_valid <= 1'b0;
    #1 chk({out_valid, out_abort, out_insn, out_priv, out_share, out_memtype, out_alloc}, exp);
  endtask
  task pulse(input [2:0] exp);
    @(posedge clk_sys);
    irq_event <= 3'h7;
    msi_req <= 3'h7;
    @(posedge clk_sys);
    irq_event <= 3'h0;
    msi_req <= 3'h0;
    #1 chk({irq_edge, msi_fire}, {exp, exp});
  endtask
  task t_reset;
    rd(12'h044);
    chk(d, `GBAR_BYPASS_RESET);
    rd(12'h054);
    chk(d, 32'h0);
    txn(1'b1, 13'h132a);
  endtask
  task t_update;
    txn(1'b0, 13'h172a);
    wr(12'h044, 32'h800e3d1f);
    wr(12'h044, 32'h80000000);
    rd(12'h044);
    chk(d, 32'h800e3d1f);
    for (int i = 0; i < 40 && d[31]; i++) rd(12'h044);
    chk(d, 32'h000e3d1f);
    txn(1'b0, 13'h15fd);
    txn(1'b1, 13'h11fd);
    wr(12'h044, 32'h00001000);
    rd(12'h044);
    chk(d, 32'h000e3d1f);
    translation_enable <= 1'b1;
    txn(1'b0, 13'h172a);
    translation_enable <= 1'b0;
    wr(12'h048, 32'ha55a0ff0);
    rd(12'h048);
    chk(d, 32'ha55a0ff0);
  endtask
  task t_abort;
    wr(12'h044, 32'h80101000);
    rd(12'h044);
    for (int i = 0; i < 40 && d[31]; i++) rd(12'h044);
    chk(d, 32'h00101000);
    txn(1'b0, 13'h1f2a);
    txn_nonsecure <= 1'b0;
    txn(1'b0, 13'h172a);
    txn_nonsecure <= 1'b1;
  endtask
  task t_irq;
    wr(12'h050, 32'h7);
    repeat (8) @(posedge clk_sys);
    rd(12'h054);
    chk(d, 32'h7);
    pulse(3'h7);
    wr(12'h050, 32'h2);
    repeat (8) @(posedge clk_sys);
    pulse(3'h2);
  endtask
  task results;
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_update;
    t_abort;
    t_irq;
    results;
  end
endmodule
